//--- rtl/pmrrp_defs.vh
/*
 * pmrrp_defs.vh: constants for the page mode rom host read controller.
 * Assumes a 125 MHz controller clock; cycle counts are derived from the
 * printed times and round least times up to whole cycles.
 */
`ifndef PMRRP_DEFS_VH
`define PMRRP_DEFS_VH

// controller clock period
`define PMRRP_CLK_NS 8

// memory organisation
`define PMRRP_WORDS 16777216
`define PMRRP_BYTES 33554432
`define PMRRP_WADDR_W 24
`define PMRRP_BADDR_W 25
`define PMRRP_DATA_W 16

// access and reset timing, printed times in ns
`define PMRRP_RANDOM_ACCESS_DELAY_NS 100
`define PMRRP_IN_PAGE_ACCESS_DELAY_NS 25
`define PMRRP_T_RP_NS 100
`define PMRRP_RESET_RELEASE_SELECT_GAP_NS 100
`define PMRRP_POWERUP_SELECT_GAP_NS 100

// least times rounded up to cycles
`define PMRRP_ACC_CYC ((`PMRRP_RANDOM_ACCESS_DELAY_NS + `PMRRP_CLK_NS - 1) / `PMRRP_CLK_NS)
`define PMRRP_PAC_CYC ((`PMRRP_IN_PAGE_ACCESS_DELAY_NS + `PMRRP_CLK_NS - 1) / `PMRRP_CLK_NS)
`define PMRRP_RP_CYC ((`PMRRP_T_RP_NS + `PMRRP_CLK_NS - 1) / `PMRRP_CLK_NS)
`define PMRRP_RCH_CYC ((`PMRRP_RESET_RELEASE_SELECT_GAP_NS + `PMRRP_CLK_NS - 1) / `PMRRP_CLK_NS)
`define PMRRP_RCS_CYC ((`PMRRP_POWERUP_SELECT_GAP_NS + `PMRRP_CLK_NS - 1) / `PMRRP_CLK_NS)

// input synchroniser depth on the data pins
`define PMRRP_SYNC_CYC 3

// reset values of the pin registers
`define PMRRP_RST_RESET_N 1'h0
`define PMRRP_RST_CE_N 1'h1
`define PMRRP_RST_OE_N 1'h1
`define PMRRP_RST_BYTE_N 1'h1
`define PMRRP_RST_TOP_OE_N 1'h1

`endif

//--- rtl/pmrrp_sync3.v
/*
 * pmrrp_sync3.v: three flip-flop synchroniser for the data pins.
 * Assumes the pins are asynchronous to clock; only the second and third
 * stages leave the module, the first feeds the second alone.
 */
`timescale 1ns/1ns
module pmrrp_sync3 #(
   parameter WIDTH = 16
) (
   input wire clock,
   input wire sys_rst,
   input wire [WIDTH-1:0] pin_in,
   output wire [WIDTH-1:0] stage2,
   output wire [WIDTH-1:0] stage3
);

   reg [WIDTH-1:0] s1_r;
   reg [WIDTH-1:0] s2_r;
   reg [WIDTH-1:0] s3_r;

   // plain shift chain; reset keeps simulation free of unknowns
   always @(posedge clock) begin
      if (sys_rst) begin
         s1_r <= {WIDTH{1'b0}};
         s2_r <= {WIDTH{1'b0}};
         s3_r <= {WIDTH{1'b0}};
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign stage2 = s2_r;
   assign stage3 = s3_r;

endmodule // pmrrp_sync3

//--- rtl/pmrrp_ctrl.v
/*
 * pmrrp_ctrl.v: host controller driving an asynchronous page mode rom,
 * with the reset sequence, random and in-page reads and byte selection.
 * Assumes the rom pins are wired straight to the ports below and that the
 * user side is synchronous to clock; the rom data pins are not, and pass
 * a three flop synchroniser before they are used.
 */
// Functional notes
// RULE1: memory holds 16M words of 16 bits, or 32M bytes by byte select.
// RULE2: in byte mode the rom floats data bits 8 to 14; host keeps bits 7:0.
// RULE3: in byte mode host drives top data pin as lowest byte address bit.
// RULE4: sample after 100 ns for new address, 25 ns for in-page change.
// RULE5: chip and output enables stay high while hardware reset is low.
// RULE6: chip enable stays high at least 100 ns after reset release.
// RULE7: at power-up chip enable high 100 ns around the reset transition.
// RULE8: rom drives data only with both enables low and reset high.
`timescale 1ns/1ns
`include "pmrrp_defs.vh"
module pmrrp_ctrl #(
   parameter PAGE_BITS = 2
) (
   input wire clock,
   input wire sys_rst,
   input wire req,
   input wire [`PMRRP_BADDR_W-1:0] req_addr,
   input wire byte_mode,
   input wire standby,
   output wire ready,
   output reg rd_valid_r,
   output reg [`PMRRP_DATA_W-1:0] rd_data_r,
   output reg [`PMRRP_WADDR_W-1:0] word_addr_bus_r,
   output reg ce_n_r,
   output reg oe_n_r,
   output reg reset_n_r,
   output reg byte_n_r,
   input wire [14:0] data_out_bus,
   input wire top_data_pin_in,
   output reg top_data_pin_out_r,
   output reg top_data_pin_oe_n_r
);

   localparam [5:0] S_RST = 6'h01;
   localparam [5:0] S_HOLD = 6'h02;
   localparam [5:0] S_IDLE = 6'h04;
   localparam [5:0] S_WAIT = 6'h08;
   localparam [5:0] S_CAPT = 6'h10;
   localparam [5:0] S_OPEN = 6'h20;

   // access waits include the synchroniser depth so the sampled word is settled;
   // full-width sums are cut to the counter width on purpose
   localparam [31:0] RP_FULL = (`PMRRP_RP_CYC > `PMRRP_RCS_CYC) ?
      `PMRRP_RP_CYC - 1 : `PMRRP_RCS_CYC - 1;
   localparam [31:0] RCH_FULL = `PMRRP_RCH_CYC - 1;
   localparam [31:0] ACC_FULL = `PMRRP_ACC_CYC + `PMRRP_SYNC_CYC - 1;
   localparam [31:0] PAC_FULL = `PMRRP_PAC_CYC + `PMRRP_SYNC_CYC - 1;
   localparam [4:0] RP_LOAD = RP_FULL[4:0];
   localparam [4:0] RCH_LOAD = RCH_FULL[4:0];
   localparam [4:0] ACC_LOAD = ACC_FULL[4:0];
   localparam [4:0] PAC_LOAD = PAC_FULL[4:0];

   reg [5:0] state_r;
   reg [5:0] state_nxt;
   reg [4:0] cnt_r;
   reg [4:0] cnt_nxt;
   reg [`PMRRP_WADDR_W-1:0] req_word;
   reg req_lsb;
   reg same_page;
   wire [`PMRRP_DATA_W-1:0] syn2;
   wire [`PMRRP_DATA_W-1:0] syn3;

   // data pins cross into the clock domain through three flops
   pmrrp_sync3 #(
      .WIDTH(`PMRRP_DATA_W)
   ) u_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .pin_in({top_data_pin_in, data_out_bus}),
      .stage2(syn2),
      .stage3(syn3)
   );

   // split the user address by organisation
   always @* begin
      if (byte_mode) begin
         req_word = req_addr[`PMRRP_BADDR_W-1:1]; // RULE1
         req_lsb = req_addr[0]; // RULE3
      end else begin
         req_word = req_addr[`PMRRP_WADDR_W-1:0]; // RULE1
         req_lsb = 1'b0;
      end
      same_page = (req_word[`PMRRP_WADDR_W-1:PAGE_BITS] ==
                   word_addr_bus_r[`PMRRP_WADDR_W-1:PAGE_BITS]);
   end

   // requests are taken only while idle or with a page held open; a mode
   // change or standby in the open page must close the chip first
   assign ready = ((state_r == S_IDLE) || (state_r == S_OPEN)) &&
                  !(state_r == S_OPEN && (standby || byte_mode == byte_n_r));

   // next state and wait counter
   always @* begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      case (state_r)
         S_RST: begin
            if (cnt_r == 5'h00) begin
               state_nxt = S_HOLD;
               cnt_nxt = RCH_LOAD; // RULE6
            end else begin
               cnt_nxt = cnt_r - 5'h01; // RULE7
            end
         end
         S_HOLD: begin
            if (cnt_r == 5'h00) begin
               state_nxt = S_IDLE; // RULE6
            end else begin
               cnt_nxt = cnt_r - 5'h01;
            end
         end
         S_IDLE: begin
            if (req && !standby) begin
               state_nxt = S_WAIT;
               cnt_nxt = ACC_LOAD; // RULE4
            end
         end
         S_WAIT: begin
            if (cnt_r == 5'h00) begin
               state_nxt = S_CAPT;
            end else begin
               cnt_nxt = cnt_r - 5'h01;
            end
         end
         S_CAPT: begin
            // settled only once the two late stages agree
            if (syn2 == syn3) begin
               state_nxt = S_OPEN;
            end
         end
         S_OPEN: begin
            if (standby || byte_mode == byte_n_r) begin
               state_nxt = S_IDLE;
            end else if (req) begin
               state_nxt = S_WAIT;
               cnt_nxt = same_page ? PAC_LOAD : ACC_LOAD; // RULE4
            end
         end
         default: begin
            state_nxt = S_RST;
            cnt_nxt = RP_LOAD;
         end
      endcase
   end

   // state and wait counter
   always @(posedge clock) begin
      if (sys_rst) begin
         state_r <= S_RST;
         cnt_r <= RP_LOAD;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // rom reset pin is released only after the full low pulse has run
   always @(posedge clock) begin
      if (sys_rst) begin
         reset_n_r <= `PMRRP_RST_RESET_N;
      end else if (state_r == S_RST && cnt_r == 5'h00) begin
         reset_n_r <= 1'h1; // RULE7
      end
   end

   // byte select only changes with the chip deselected, so the top pin
   // never turns round while the rom may be driving bit 15
   always @(posedge clock) begin
      if (sys_rst) begin
         byte_n_r <= `PMRRP_RST_BYTE_N;
         top_data_pin_oe_n_r <= `PMRRP_RST_TOP_OE_N;
      end else if (state_r == S_IDLE || state_r == S_HOLD) begin
         byte_n_r <= ~byte_mode;
         top_data_pin_oe_n_r <= ~byte_mode; // RULE3
      end
   end

   // address and enables: a taken request opens the chip; it is closed
   // again only on the way back to idle or during the reset sequence
   always @(posedge clock) begin
      if (sys_rst) begin
         ce_n_r <= `PMRRP_RST_CE_N; // RULE5
         oe_n_r <= `PMRRP_RST_OE_N; // RULE5
         word_addr_bus_r <= {`PMRRP_WADDR_W{1'b0}};
         top_data_pin_out_r <= 1'h0;
      end else if (ready && req && !standby) begin
         word_addr_bus_r <= req_word;
         top_data_pin_out_r <= req_lsb; // RULE3
         ce_n_r <= 1'h0; // RULE8
         oe_n_r <= 1'h0; // RULE8
      end else if (state_nxt == S_IDLE || state_r == S_RST || state_r == S_HOLD) begin
         ce_n_r <= 1'h1; // RULE6
         oe_n_r <= 1'h1; // RULE5
      end
   end

   // read data capture; byte mode ignores the floating upper bits, and
   // only a word that both late synchroniser stages agree on is taken
   always @(posedge clock) begin
      if (sys_rst) begin
         rd_valid_r <= 1'h0;
         rd_data_r <= 16'h0000;
      end else begin
         rd_valid_r <= 1'h0;
         if (state_r == S_CAPT && syn2 == syn3) begin
            rd_valid_r <= 1'h1;
            if (!byte_n_r) begin
               rd_data_r <= {8'h00, syn3[7:0]}; // RULE2
            end else begin
               rd_data_r <= syn3;
            end
         end
      end
   end

endmodule // pmrrp_ctrl

//--- tb/pmrrp_monitor.sv
/* pmrrp_monitor.sv: assertions on the rom pins and read answers of the read controller.
   assumes binding onto pmrrp_ctrl and a single clock domain. */
`timescale 1ns/1ns
module pmrrp_monitor (
   input wire clock,
   input wire sys_rst,
   input wire req,
   input wire standby,
   input wire ready,
   input wire rd_valid_r,
   input wire ce_n_r,
   input wire oe_n_r,
   input wire reset_n_r,
   input wire byte_n_r,
   input wire top_data_pin_oe_n_r
);
   reg [4:0] hi_r = 5'h00;
   reg [4:0] lo_r = 5'h00;
   wire take = req && ready && !standby;
   // saturating counts of time spent with rom reset high and low; cleared by
   // sys_rst so an unknown pin before the first edge cannot stick in them
   always @(posedge clock) begin
      if (sys_rst) begin
         hi_r <= 5'h00;
         lo_r <= 5'h00;
      end else begin
         hi_r <= !reset_n_r ? 5'h00 : (hi_r == 5'h1F ? hi_r : hi_r + 5'h01);
         lo_r <= reset_n_r ? 5'h00 : (lo_r == 5'h1F ? lo_r : lo_r + 5'h01);
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   rst_quiet_a: assert property (!reset_n_r |-> ce_n_r && oe_n_r)
      else $error("enable low while rom reset low");
   rel_gap_a: assert property (!ce_n_r |-> hi_r >= 5'h0D)
      else $error("chip enable too soon after reset release");
   pulse_width_a: assert property ($rose(reset_n_r) |-> lo_r >= 5'h0D)
      else $error("rom reset pulse too short");
   word_pin_a: assert property (byte_n_r |-> top_data_pin_oe_n_r)
      else $error("top pin driven in word mode");
   byte_pin_a: assert property (!byte_n_r && !ce_n_r |-> !top_data_pin_oe_n_r)
      else $error("top pin not driven in byte mode");
   min_wait_a: assert property (take |=> !rd_valid_r [*7])
      else $error("data taken before access time");
   read_answer_a: assert property (take |-> ##[8:60] rd_valid_r)
      else $error("read never answered");
   word_read_c: cover property (take && byte_n_r);
   byte_read_c: cover property (take && !byte_n_r);
   reset_rel_c: cover property ($rose(reset_n_r));
endmodule // pmrrp_monitor

bind pmrrp_ctrl pmrrp_monitor u_mon (.clock(clock), .sys_rst(sys_rst), .req(req),
   .standby(standby), .ready(ready), .rd_valid_r(rd_valid_r), .ce_n_r(ce_n_r),
   .oe_n_r(oe_n_r), .reset_n_r(reset_n_r), .byte_n_r(byte_n_r),
   .top_data_pin_oe_n_r(top_data_pin_oe_n_r));

//--- tb/pmrrp_rom_model.sv
/* pmrrp_rom_model.sv: behavioural page mode rom facing the controller.
   assumes no pulls on the data pins, so stale or floating data shows inverted. */
`timescale 1ns/1ns
module pmrrp_rom_model (
   input wire [23:0] word_addr_bus,
   input wire ce_n,
   input wire oe_n,
   input wire reset_n,
   input wire byte_n,
   input wire top_pin,
   output wire [14:0] data_out_bus,
   output wire top_out
);
   wire [15:0] w = word_addr_bus[15:0] ^ {2{word_addr_bus[23:16]}};
   // top pin only counts as address in byte mode, avoiding a loop on our own output
   wire [27:0] key = {ce_n, reset_n, byte_n, top_pin & ~byte_n, word_addr_bus};
   wire [24:0] pkey = {ce_n, reset_n, byte_n, word_addr_bus[23:2]};
   wire [27:0] key100, key25;
   wire [24:0] pkey100;
   // inertial copies only catch up once the source has been quiet that long
   assign #100 key100 = key;
   assign #25 key25 = key;
   assign #100 pkey100 = pkey;
   wire ok = (key100 === key) || (pkey100 === pkey && key25 === key);
   wire drv = !ce_n && !oe_n && reset_n && ok;
   wire [7:0] b = top_pin ? w[15:8] : w[7:0];
   assign data_out_bus = !drv ? ~w[14:0] : byte_n ? w[14:0] : {~w[14:8], b};
   assign top_out = (drv && byte_n) ? w[15] : ~w[15];
endmodule // pmrrp_rom_model

//--- tb/tb.sv
/* tb.sv: self-checking bench for the page mode rom read controller.
   assumes the rom model on the pins and a 125 MHz clock. */
`timescale 1ns/1ns
module tb;
   reg clock = 1'b0;
   reg sys_rst = 1'b1;
   reg req = 1'b0;
   reg [24:0] req_addr = 25'h0000000;
   reg byte_mode = 1'b0;
   reg standby = 1'b0;
   wire ready, rd_valid_r, ce_n_r, oe_n_r, reset_n_r, byte_n_r, t_out, t_oe_n, rom_top;
   wire [15:0] rd_data_r;
   wire [23:0] wa;
   wire [14:0] dbus;
   wire top_pin = t_oe_n ? rom_top : t_out;
   integer fails = 0;
   integer n_checks = 0;
   integer cyc = 0;
   initial forever #4 clock = ~clock;
   pmrrp_ctrl dut (.clock(clock), .sys_rst(sys_rst), .req(req), .req_addr(req_addr),
      .byte_mode(byte_mode), .standby(standby), .ready(ready), .rd_valid_r(rd_valid_r),
      .rd_data_r(rd_data_r), .word_addr_bus_r(wa), .ce_n_r(ce_n_r), .oe_n_r(oe_n_r),
      .reset_n_r(reset_n_r), .byte_n_r(byte_n_r), .data_out_bus(dbus),
      .top_data_pin_in(top_pin), .top_data_pin_out_r(t_out), .top_data_pin_oe_n_r(t_oe_n));
   pmrrp_rom_model rom (.word_addr_bus(wa), .ce_n(ce_n_r), .oe_n(oe_n_r),
      .reset_n(reset_n_r), .byte_n(byte_n_r), .top_pin(top_pin), .data_out_bus(dbus),
      .top_out(rom_top));
   task tally_and_finish;
      begin
         $display("checks %0d fails %0d", n_checks, fails);
         if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // a hang is cut short well beyond the few hundred cycles the run needs
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails = fails + 1;
         tally_and_finish;
      end
   end
   task chk_eq(input string nm, input [15:0] e, input [15:0] g);
      begin
         n_checks = n_checks + 1;
         if (g !== e) begin
            fails = fails + 1;
            $display("mismatch %s exp %h got %h", nm, e, g);
         end
      end
   endtask
   task chk_min(input string nm, input integer lo, input integer g);
      begin
         n_checks = n_checks + 1;
         if (g < lo) begin
            fails = fails + 1;
            $display("mismatch %s exp >=%0d got %0d", nm, lo, g);
         end
      end
   endtask
   function [15:0] ew(input [23:0] a);
      ew = a[15:0] ^ {2{a[23:16]}};
   endfunction
   function [15:0] eb(input [24:0] a);
      reg [15:0] w;
      begin
         w = ew(a[24:1]);
         eb = {8'h00, a[0] ? w[15:8] : w[7:0]};
      end
   endfunction
   // one read: request held until the taking edge, then the answer is timed
   task rd(input [24:0] a, input [15:0] e, input integer lmin);
      integer n;
      begin
         n = 0;
         @(posedge clock) #1;
         while (ready !== 1'b1) @(posedge clock) #1;
         @(posedge clock) req <= 1'b1;
         req_addr <= a;
         @(posedge clock) req <= 1'b0;
         while (rd_valid_r !== 1'b1 && n < 60) begin
            @(posedge clock) #1;
            n = n + 1;
         end
         chk_min("latency", lmin, n);
         chk_eq("rd_valid", 16'h0001, {15'h0000, rd_valid_r});
         chk_eq("rd_data", e, rd_data_r);
      end
   endtask
   task t_word;
      begin
         rd(25'h0ABCDE4, ew(24'hABCDE4), 17);
         rd(25'h0ABCDE7, ew(24'hABCDE7), 8);
         rd(25'h0FFFFFF, ew(24'hFFFFFF), 17);
      end
   endtask
   // a closed page must pay the full access time again
   task t_standby;
      begin
         @(posedge clock) standby <= 1'b1;
         repeat (4) @(posedge clock);
         #1;
         chk_eq("standby_ce_n", 16'h0001, {15'h0000, ce_n_r});
         @(posedge clock) standby <= 1'b0;
         rd(25'h0FFFFFC, ew(24'hFFFFFC), 17);
      end
   endtask
   task t_byte;
      begin
         @(posedge clock) byte_mode <= 1'b1;
         rd(25'h1ABCDE9, eb(25'h1ABCDE9), 17);
         rd(25'h1ABCDE8, eb(25'h1ABCDE8), 8);
         @(posedge clock) byte_mode <= 1'b0;
      end
   endtask
   task t_rerst;
      begin
         @(posedge clock) sys_rst <= 1'b1;
         repeat (12) @(posedge clock);
         #1;
         chk_eq("ce_n", 16'h0001, {15'h0000, ce_n_r});
         chk_eq("oe_n", 16'h0001, {15'h0000, oe_n_r});
         chk_eq("reset_n", 16'h0000, {15'h0000, reset_n_r});
         @(posedge clock) sys_rst <= 1'b0;
         rd(25'h0012344, ew(24'h012344), 17);
      end
   endtask
   initial begin
      repeat (12) @(posedge clock);
      sys_rst <= 1'b0;
      t_word;
      t_standby;
      t_byte;
      t_rerst;
      tally_and_finish;
   end
endmodule // tb
